// [rtl/btce_defines.svh]
// Constants for the bit-test and compare execution block.
`ifndef BTCE_DEFINES_SVH
`define BTCE_DEFINES_SVH
`define BTCE_DATA_W 16
`define BTCE_FLAG_C 0
`define BTCE_FLAG_DC 1
`define BTCE_FLAG_N 2
`define BTCE_FLAG_OV 3
`define BTCE_FLAG_Z 4
`define BTCE_DC_BIT 4
`define BTCE_LIT5_W 5
`define BTCE_ZERO_WORD 16'h0000
`define BTCE_FLAGS_RST 5'h00
`define BTCE_SKIP_ONE_WORD 2'h1
`define BTCE_SKIP_TWO_WORD 2'h2
`endif

// [rtl/btce_pkg.sv]
// Types shared by the bit-test and compare execution block.
package btce_pkg;
    typedef enum logic [3:0] {
        BTCE_OP_NONE = 4'h0,
        BTCE_OP_SKIP_CLR = 4'h1,
        BTCE_OP_SKIP_SET = 4'h2,
        BTCE_OP_PROBE = 4'h3,
        BTCE_OP_PROBE_FORCE = 4'h4,
        BTCE_OP_SUB_CMP = 4'h5,
        BTCE_OP_CMP_ZERO = 4'h6,
        BTCE_OP_CMP_BORROW = 4'h7,
        BTCE_OP_SKIP_EQ = 4'h8,
        BTCE_OP_SKIP_NE = 4'h9,
        BTCE_OP_SKIP_GT = 4'hA,
        BTCE_OP_SKIP_LT = 4'hB
    } btce_op_t;

    typedef enum logic [1:0] {
        BTCE_SRC_DEFAULT_WORK_REG = 2'h0,
        BTCE_SRC_LIT = 2'h1,
        BTCE_SRC_FILE = 2'h2
    } btce_src_t;

    typedef struct packed {
        logic valid;
        btce_op_t op;
        btce_src_t src;
        logic to_zero;
        logic reg_index;
        logic [3:0] bit_idx;
        logic [4:0] lit;
        logic [15:0] base_val;
        logic [15:0] src_val;
        logic [15:0] file_val;
        logic [15:0] dflt_val;
        logic [15:0] index_val;
    } btce_req_t;

    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
    } btce_flags_t;
endpackage : btce_pkg

// [rtl/btce_sub_unit.sv]
// Subtractor that produces the five arithmetic flags for a compare.
`timescale 1ns/1ps
`include "btce_defines.svh"
module btce_sub_unit (
    input wire logic [15:0] minuend,
    input wire logic [15:0] subtrahend,
    input wire logic borrow_in,
    output btce_pkg::btce_flags_t flags
);
    import btce_pkg::*;

    wire [16:0] diff_full;
    wire [4:0] diff_low;
    wire [15:0] diff;

    // The carry reads as not-borrow, so borrow_in subtracts one more.
    assign diff_full = {1'b0, minuend} + {1'b0, ~subtrahend} +
                       {16'h0000, ~borrow_in};
    assign diff_low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} +
                      {4'h0, ~borrow_in};
    assign diff = diff_full[15:0];
    assign flags.c = diff_full[16];
    assign flags.dc = diff_low[`BTCE_DC_BIT];
    assign flags.n = diff[15];
    assign flags.ov = (minuend[15] != subtrahend[15]) &&
                      (diff[15] != minuend[15]);
    assign flags.z = (diff == `BTCE_ZERO_WORD);
endmodule : btce_sub_unit

// [rtl/btce_exec.sv]
// Execution unit for bit tests, compares and compare-and-skip operations.
`timescale 1ns/1ps
`include "btce_defines.svh"
// Function
// - Immediate-index bit test skips next instruction when bit is zero.
// - Immediate-index bit test skips next instruction when bit is one.
// - Register-indexed probe copies selected bit into carry only, one cycle.
// - Register-indexed probe reports selected bit through zero flag only.
// - Probe-then-force captures bit into carry or zero, then sets it.
// - Register compare sets five flags from base minus source.
// - Literal compare subtracts zero-extended five-bit literal, flags only.
// - Compare against zero sets five flags, writes no destination.
// - Compare with borrow subtracts inverted carry too, flags only.
// - File form with borrow uses file minus default register.
// - Skip-on-equal skips when registers match, flags untouched.
// - Skip-on-unequal skips when registers differ, flags untouched.
// - Skip-on-greater skips when base exceeds other operand.
// - Skip-on-less skips when base is below other operand.
module btce_exec (
    input wire logic core_clk,
    input wire logic rst_n,
    input btce_pkg::btce_req_t req,
    input wire logic next_two_word,
    output btce_pkg::btce_flags_t flags_r,
    output logic [15:0] wr_data_r,
    output logic wr_en_r,
    output logic skip_r,
    output logic busy_r,
    output logic done_r
);
    import btce_pkg::*;

    typedef enum logic [2:0] {
        BTCE_ST_IDLE = 3'b001,
        BTCE_ST_SKIP1 = 3'b010,
        BTCE_ST_SKIP2 = 3'b100
    } btce_state_t;

    btce_state_t state_r;
    btce_state_t state_nxt;
    btce_flags_t flags_nxt;
    btce_flags_t sub_flags;

    wire take;
    wire [3:0] sel_idx;
    wire sel_bit;
    wire [15:0] min_val;
    wire [15:0] sub_val;
    wire borrow_in;
    wire arith_op;
    logic skip_cond;
    wire [15:0] set_mask;

    assign take = req.valid && (state_r == BTCE_ST_IDLE);
    // Only the low four bits of the index register matter on 16-bit data.
    assign sel_idx = req.reg_index ? req.index_val[3:0] : req.bit_idx;
    assign sel_bit = req.src_val[sel_idx];
    assign set_mask = 16'h0001 << sel_idx;

    // File forms other than compare against zero compare the file register against the default register.
    assign min_val = (req.src == BTCE_SRC_FILE) ? req.file_val :
                     (req.op == BTCE_OP_CMP_ZERO) ? req.src_val :
                     req.base_val;
    assign sub_val = (req.op == BTCE_OP_CMP_ZERO) ? `BTCE_ZERO_WORD :
                     (req.src == BTCE_SRC_FILE) ? req.dflt_val :
                     (req.src == BTCE_SRC_LIT) ? {11'h000, req.lit} :
                     req.src_val;
    assign borrow_in = (req.op == BTCE_OP_CMP_BORROW) ? ~flags_r.c : 1'b0;
    assign arith_op = (req.op == BTCE_OP_SUB_CMP) ||
                      (req.op == BTCE_OP_CMP_ZERO) ||
                      (req.op == BTCE_OP_CMP_BORROW);

    btce_sub_unit u_sub (
        .minuend(min_val),
        .subtrahend(sub_val),
        .borrow_in(borrow_in),
        .flags(sub_flags)
    );

    always_comb begin
        unique case (req.op)
            BTCE_OP_SKIP_CLR: skip_cond = ~sel_bit;
            BTCE_OP_SKIP_SET: skip_cond = sel_bit;
            BTCE_OP_SKIP_EQ: skip_cond = req.base_val == req.src_val;
            BTCE_OP_SKIP_NE: skip_cond = req.base_val != req.src_val;
            BTCE_OP_SKIP_GT: skip_cond = $signed(req.base_val) >
                                         $signed(req.src_val);
            BTCE_OP_SKIP_LT: skip_cond = $signed(req.base_val) <
                                         $signed(req.src_val);
            default: skip_cond = 1'b0;
        endcase
    end

    always_comb begin
        flags_nxt = flags_r;
        if (take && arith_op) begin
            flags_nxt = sub_flags;
        end else if (take && ((req.op == BTCE_OP_PROBE) ||
                              (req.op == BTCE_OP_PROBE_FORCE))) begin
            // The zero flag holds the complement of the probed bit.
            if (req.to_zero) begin
                flags_nxt.z = ~sel_bit;
            end else begin
                flags_nxt.c = sel_bit;
            end
        end
    end

    // A two-word follower needs a second flushed fetch slot.
    always_comb begin
        state_nxt = BTCE_ST_IDLE;
        unique case (state_r)
            BTCE_ST_IDLE: begin
                if (take && skip_cond) begin
                    state_nxt = next_two_word ? BTCE_ST_SKIP2 :
                                BTCE_ST_SKIP1;
                end
            end
            BTCE_ST_SKIP2: state_nxt = BTCE_ST_SKIP1;
            BTCE_ST_SKIP1: state_nxt = BTCE_ST_IDLE;
            default: state_nxt = BTCE_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BTCE_ST_IDLE;
            flags_r <= `BTCE_FLAGS_RST;
            wr_data_r <= `BTCE_ZERO_WORD;
            wr_en_r <= 1'b0;
            skip_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            wr_data_r <= req.src_val | set_mask;
            wr_en_r <= take && (req.op == BTCE_OP_PROBE_FORCE);
            skip_r <= take && skip_cond;
            busy_r <= state_nxt != BTCE_ST_IDLE;
            done_r <= take || (state_r == BTCE_ST_SKIP1);
        end
    end

    sequence s_skip_two;
        take && skip_cond && next_two_word;
    endsequence

    sequence s_skip_one;
        take && skip_cond && !next_two_word;
    endsequence

    a_skip_two_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_skip_two |=> busy_r [*2] ##1 !busy_r)
        else $error("two-word skip length wrong");
    a_skip_one_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_skip_one |=> busy_r ##1 !busy_r)
        else $error("one-word skip length wrong");
    a_skip_clr_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_SKIP_CLR |=> skip_r == !$past(sel_bit))
        else $error("skip on clear bit wrong");
    a_skip_set_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_SKIP_SET |=> skip_r == $past(sel_bit))
        else $error("skip on set bit wrong");
    a_skip_flags_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        take && !arith_op && req.op != BTCE_OP_PROBE &&
        req.op != BTCE_OP_PROBE_FORCE |=> $stable(flags_r))
        else $error("skip changed flags");
    a_probe_carry: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_PROBE && !req.to_zero
        |=> flags_r.c == $past(sel_bit) && flags_r.z == $past(flags_r.z))
        else $error("carry probe wrong");
    a_probe_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_PROBE && req.to_zero
        |=> flags_r.z == !$past(sel_bit) && flags_r.c == $past(flags_r.c))
        else $error("zero probe wrong");
    a_force_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_PROBE_FORCE
        |=> wr_en_r && wr_data_r[$past(sel_idx)])
        else $error("force one not written");
    a_cmp_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_SUB_CMP && req.src == BTCE_SRC_DEFAULT_WORK_REG
        |=> flags_r.z == ($past(req.base_val) == $past(req.src_val)) &&
            !wr_en_r)
        else $error("compare zero flag wrong");
    a_gt_signed: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && req.op == BTCE_OP_SKIP_GT && req.base_val == 16'h7FFF &&
        req.src_val == 16'h8000 |=> skip_r)
        else $error("signed greater wrong");
endmodule : btce_exec

// [testbench/testbench.sv]
// Self-checking bench for the bit-test and compare execution unit.
`timescale 1ns/1ps
module testbench;
    import btce_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    btce_req_t req = '0;
    logic next_two_word = 1'b0;
    btce_flags_t flags_r;
    logic [15:0] wr_data_r;
    logic wr_en_r;
    logic skip_r;
    logic busy_r;
    logic done_r;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 32'h4674;
    btce_flags_t mf = '0;

    always #25 core_clk = ~core_clk;

    btce_exec btce_exec_i (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .next_two_word(next_two_word), .flags_r(flags_r),
        .wr_data_r(wr_data_r), .wr_en_r(wr_en_r), .skip_r(skip_r),
        .busy_r(busy_r), .done_r(done_r));

    task automatic cmp_flags(input btce_flags_t e, input btce_flags_t a);
        checks_done++;
        if (a !== e) begin
            bad_count++;
            $display("[FAIL] %0t flags exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_flags

    task automatic cmp_bit(input logic e, input logic a);
        checks_done++;
        if (a !== e) begin
            bad_count++;
            $display("[FAIL] %0t bit exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [15:0] e, input logic [15:0] a);
        checks_done++;
        if (a !== e) begin
            bad_count++;
            $display("[FAIL] %0t word exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_word

    task automatic final_report();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Sign boundaries are favoured because overflow and signed skips hinge there.
    function automatic logic [15:0] pick();
        int s;
        s = $random(seed) & 3;
        if (s == 0) return 16'h8000;
        if (s == 1) return 16'h7FFF;
        return 16'($random(seed));
    endfunction : pick

    task automatic sub_flags(input int a, input int b, input int bw);
        int r;
        r = (a - b - bw) & 32'hFFFF;
        mf.c = (a - b - bw) >= 0;
        mf.dc = ((a & 15) - (b & 15) - bw) >= 0;
        mf.n = r[15];
        mf.ov = (((a ^ b) & (a ^ r)) & 32'h8000) != 0;
        mf.z = (r == 0);
    endtask : sub_flags

    task automatic run_op(input btce_req_t q, input logic two);
        int idx;
        int a;
        int b;
        logic bitv;
        logic sk;
        logic wr;
        req = q;
        next_two_word = two;
        @(posedge core_clk);
        @(negedge core_clk);
        idx = q.reg_index ? q.index_val[3:0] : q.bit_idx;
        bitv = q.src_val[idx];
        a = (q.src == BTCE_SRC_FILE) ? q.file_val : q.base_val;
        b = (q.src == BTCE_SRC_FILE) ? q.dflt_val :
            (q.src == BTCE_SRC_LIT) ? int'(q.lit) : q.src_val;
        sk = 1'b0;
        wr = (q.op == BTCE_OP_PROBE_FORCE);
        case (q.op)
            BTCE_OP_SKIP_CLR: sk = !bitv;
            BTCE_OP_SKIP_SET: sk = bitv;
            BTCE_OP_PROBE, BTCE_OP_PROBE_FORCE: begin
                if (q.to_zero) mf.z = !bitv;
                else mf.c = bitv;
            end
            BTCE_OP_SUB_CMP: sub_flags(a, b, 0);
            BTCE_OP_CMP_ZERO: sub_flags((q.src == BTCE_SRC_FILE) ?
                q.file_val : q.src_val, 0, 0);
            BTCE_OP_CMP_BORROW: sub_flags(a, b, !mf.c);
            BTCE_OP_SKIP_EQ: sk = (q.base_val == q.src_val);
            BTCE_OP_SKIP_NE: sk = (q.base_val != q.src_val);
            BTCE_OP_SKIP_GT: sk = $signed(q.base_val) > $signed(q.src_val);
            BTCE_OP_SKIP_LT: sk = $signed(q.base_val) < $signed(q.src_val);
            default: ;
        endcase
        cmp_bit(1'b1, done_r);
        cmp_flags(mf, flags_r);
        cmp_bit(sk, skip_r);
        cmp_bit(wr, wr_en_r);
        if (wr) cmp_word(q.src_val | (16'h1 << idx), wr_data_r);
        cmp_bit(sk, busy_r);
        if (sk) begin
            // A flag-changing request offered while busy must be dropped.
            req.op = BTCE_OP_SUB_CMP;
            req.base_val = 16'($random(seed));
            for (int k = 1; k <= (two ? 2 : 1); k++) begin
                @(negedge core_clk);
                if (k == 1) req.valid = 1'b0;
                cmp_bit(k == (two ? 2 : 1), done_r);
                cmp_bit(k < (two ? 2 : 1), busy_r);
            end
            @(negedge core_clk);
            cmp_bit(1'b0, done_r);
            cmp_flags(mf, flags_r);
        end
    endtask : run_op

    task automatic reset_check();
        cmp_flags(5'h00, flags_r);
        cmp_bit(1'b0, busy_r);
        cmp_bit(1'b0, skip_r);
        cmp_bit(1'b0, done_r);
        cmp_bit(1'b0, wr_en_r);
    endtask : reset_check

    initial begin : main
        btce_req_t q;
        repeat (5) @(negedge core_clk);
        reset_check();
        rst_n = 1'b1;
        for (int i = 0; i < 660; i++) begin
            q = '0;
            q.valid = 1'b1;
            q.op = btce_op_t'(4'(i % 11 + 1));
            q.src = btce_src_t'(2'($unsigned($random(seed)) % 3));
            if (q.op == BTCE_OP_CMP_ZERO && q.src == BTCE_SRC_LIT)
                q.src = BTCE_SRC_FILE;
            if (q.op < BTCE_OP_SUB_CMP || q.op > BTCE_OP_CMP_BORROW)
                q.src = BTCE_SRC_DEFAULT_WORK_REG;
            q.to_zero = 1'($random(seed));
            q.reg_index = 1'($random(seed));
            q.bit_idx = 4'($random(seed));
            q.lit = 5'($random(seed));
            q.base_val = pick();
            q.src_val = (i % 4 == 0) ? q.base_val : pick();
            q.file_val = pick();
            q.dflt_val = pick();
            q.index_val = 16'($random(seed));
            if (i == 330) begin
                rst_n = 1'b0;
                req.valid = 1'b0;
                mf = '0;
                @(negedge core_clk);
                reset_check();
                rst_n = 1'b1;
            end
            run_op(q, 1'($random(seed)));
        end
        final_report();
    end

    // The run needs well under 4000 cycles, so this only fires on a hang.
    initial begin : watchdog
        #2000000;
        bad_count++;
        final_report();
    end
endmodule : testbench
